/* hdl/ups_top.sv */
// usb power state pins: power enable, suspend, power save and config memory pins
//
// Behaviour
// [RULE1] power enable low only when configured, awake
// [RULE2] suspend output low while link suspended
// [RULE3] low power-save input forces suspend when enabled
// [RULE4] power-save honoured only when config memory enables
// [RULE5] memory select, clock, data tristated during reset
// [RULE6] memory clock driven outside reset
// [RULE7] reset input is active low from outside
// [RULE8] reset release synchronised before leaving reset
`timescale 1ns/10ps
`default_nettype none
module ups_top (
  input wire logic i_ref_clk,          // 100 MHz reference clock
  input wire logic i_resetn,           // asynchronous reset, active low
  input wire logic i_link_suspend,     // usb link in suspend, from link logic
  input wire logic i_configured,       // host has configured the device
  input wire logic i_host_presence_n,  // power save pin, asynchronous
  input wire logic i_cfg_mem_io,       // memory data pin input
  output logic o_power_enable_n,       // low during normal operation
  output logic o_suspend_n,            // low while suspended
  output logic o_cfg_mem_select,       // memory chip select
  output logic o_cfg_mem_select_oe,    // select driven
  output logic o_cfg_mem_clock,        // memory clock
  output logic o_cfg_mem_clock_oe,     // clock driven
  output logic o_cfg_mem_io,           // memory data out
  output logic o_cfg_mem_io_oe,        // data driven
  output logic o_cfg_valid             // configuration word loaded
);

  // ----------------------------------------
  // reset release synchroniser
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire logic run;

  always_ff @(posedge i_ref_clk or negedge i_resetn) // [RULE7]
  begin
    if (!i_resetn)
    begin
      rst_meta_reg <= ups_pkg::RESET_ZERO;
      rst_sync_reg <= ups_pkg::RESET_ZERO;
    end
    else
    begin
      rst_meta_reg <= ups_pkg::RESET_ONE;
      rst_sync_reg <= rst_meta_reg; // [RULE8]
    end
  end
  assign run = rst_sync_reg;

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  logic psave_meta_reg;
  logic psave_sync_reg;
  logic dio_meta_reg;
  logic dio_sync_reg;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      psave_meta_reg <= 1'h1;
      psave_sync_reg <= 1'h1;
      dio_meta_reg <= 1'h1;
      dio_sync_reg <= 1'h1;
    end
    else
    begin
      psave_meta_reg <= i_host_presence_n;
      psave_sync_reg <= psave_meta_reg;
      dio_meta_reg <= i_cfg_mem_io;
      dio_sync_reg <= dio_meta_reg;
    end
  end

  // ----------------------------------------
  // memory clock divider
  // ----------------------------------------
  logic [ups_pkg::DIV_W-1:0] div_reg;
  logic tick;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      div_reg <= '0;
    else if (!run || div_reg == ups_pkg::DIV_W'(ups_pkg::MEM_HALF_CYC - 1))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign tick = run && (div_reg == ups_pkg::DIV_W'(ups_pkg::MEM_HALF_CYC - 1));

  // ----------------------------------------
  // configuration word read sequence
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD  = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } ups_state_type;

  ups_state_type state_reg;
  logic sclk_reg;
  logic [ups_pkg::BIT_CNT_W-1:0] bit_reg;
  logic [ups_pkg::CMD_W-1:0] cmd_reg;
  logic [ups_pkg::DATA_W-1:0] data_reg;
  logic psave_en_reg;

  // each bit: rising edge of sclk on odd tick samples, falling edge shifts
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= ST_IDLE;
      sclk_reg <= 1'h0;
      bit_reg <= '0;
      cmd_reg <= '0;
      data_reg <= '0;
      psave_en_reg <= 1'h0;
    end
    else if (tick)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cmd_reg <= ups_pkg::CMD_READ0;
          bit_reg <= '0;
          sclk_reg <= 1'h0;
          state_reg <= ST_CMD;
        end
        ST_CMD:
        begin
          sclk_reg <= !sclk_reg;
          if (sclk_reg)
          begin
            cmd_reg <= {cmd_reg[ups_pkg::CMD_W-2:0], 1'b0};
            if (bit_reg == ups_pkg::BIT_CNT_W'(ups_pkg::CMD_W - 1))
            begin
              bit_reg <= '0;
              state_reg <= ST_DATA;
            end
            else
              bit_reg <= bit_reg + 1'b1;
          end
        end
        ST_DATA:
        begin
          sclk_reg <= !sclk_reg;
          if (!sclk_reg)
            data_reg <= {data_reg[ups_pkg::DATA_W-2:0], dio_sync_reg};
          else if (bit_reg == ups_pkg::BIT_CNT_W'(ups_pkg::DATA_W - 1))
          begin
            psave_en_reg <= data_reg[ups_pkg::PSAVE_BIT]; // [RULE4]
            state_reg <= ST_DONE;
          end
          else
            bit_reg <= bit_reg + 1'b1;
        end
        ST_DONE:
          sclk_reg <= 1'h0;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cfg_mem_select_oe <= 1'h0; // [RULE5]
      o_cfg_mem_clock_oe <= 1'h0;
      o_cfg_mem_io_oe <= 1'h0;
      o_cfg_mem_select <= 1'h0;
      o_cfg_mem_clock <= 1'h0;
      o_cfg_mem_io <= 1'h0;
      o_cfg_valid <= 1'h0;
    end
    else
    begin
      o_cfg_mem_select_oe <= run;
      o_cfg_mem_clock_oe <= run; // [RULE6]
      o_cfg_mem_io_oe <= run && (state_reg == ST_CMD);
      o_cfg_mem_select <= (state_reg == ST_CMD) || (state_reg == ST_DATA);
      o_cfg_mem_clock <= sclk_reg; // [RULE6]
      o_cfg_mem_io <= cmd_reg[ups_pkg::CMD_W-1];
      o_cfg_valid <= (state_reg == ST_DONE);
    end
  end

  // ----------------------------------------
  // suspend and power enable
  // ----------------------------------------
  logic suspended;
  // power save only counts once the memory word is known, avoiding a wrong early force
  assign suspended = i_link_suspend || (psave_en_reg && !psave_sync_reg); // [RULE3]

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_suspend_n <= 1'h1;
      o_power_enable_n <= 1'h1;
    end
    else
    begin
      o_suspend_n <= !suspended; // [RULE2]
      o_power_enable_n <= suspended || !i_configured || !run; // [RULE1]
    end
  end

endmodule
`default_nettype wire

/* hdl/ups_pkg.sv */
// constants for the usb power state pin block
package ups_pkg;
  // reference clock rate and configuration memory clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MEM_CLK_HZ = 1_000_000;
  // half period of the memory clock in reference cycles
  localparam int unsigned MEM_HALF_CYC = CLK_HZ / (2 * MEM_CLK_HZ);
  localparam int unsigned DIV_W = 8;
  // configuration word: read at address 0, 16 bits, bit 0 enables power save
  localparam int unsigned CMD_W = 9;
  localparam logic [8:0] CMD_READ0 = 9'h180;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PSAVE_BIT = 0;
  localparam int unsigned BIT_CNT_W = 5;
  localparam logic [0:0] RESET_ONE = 1'h1;
  localparam logic [0:0] RESET_ZERO = 1'h0;
endpackage

/* tb/ups_mem.sv */
// serial configuration memory model answering the word given by the bench
`timescale 1ns/10ps
`default_nettype none
module ups_mem (
  input wire logic i_sel, // chip select
  input wire logic i_clk, // memory clock
  input wire logic i_din, // command bits from the block
  input wire logic [15:0] i_word, // word answered
  output logic o_dout, // data out
  output logic [8:0] o_cmd // command bits seen, first bit highest
);
  int cnt = 0;
  initial o_dout = 1'b1;
  initial o_cmd = '0;
  always @(posedge i_clk or negedge i_sel)
    cnt <= i_sel ? cnt + 1 : 0;
  // command bits are taken at the rising memory clock, before the word
  always @(posedge i_clk)
    if (i_sel && cnt < 9)
      o_cmd <= {o_cmd[7:0], i_din};
  // pull-up holds the line high whenever the word is not being shifted
  always @(negedge i_clk or negedge i_sel)
    o_dout <= (i_sel && cnt >= 9 && cnt < 25) ? i_word[24 - cnt] : 1'b1;
endmodule
`default_nettype wire

/* tb/ups_top_chk.sv */
// checker for the usb power state pins
`timescale 1ns/10ps
`default_nettype none
module ups_top_chk (
  input wire logic i_ref_clk, // clk
  input wire logic i_resetn, // rst
  input wire logic i_link_suspend, // in
  input wire logic i_configured, // in
  input wire logic i_host_presence_n, // in
  input wire logic o_power_enable_n, // out
  input wire logic o_suspend_n, // out
  input wire logic o_cfg_mem_select_oe, // out
  input wire logic o_cfg_mem_clock, // out
  input wire logic o_cfg_mem_clock_oe, // out
  input wire logic o_cfg_valid // out
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  pin_release_a: assert property ($rose(i_resetn) |-> !o_cfg_mem_clock_oe ##[1:4] o_cfg_mem_clock_oe)
    else $error("memory pins not enabled after release");
  oe_hold_a: assert property (o_cfg_mem_clock_oe |=> o_cfg_mem_clock_oe && o_cfg_mem_select_oe)
    else $error("memory pins released out of reset");
  clk_half_a: assert property ($rose(o_cfg_mem_clock) |=> $stable(o_cfg_mem_clock)[*8])
    else $error("memory clock high too short");
  pwr_off_a: assert property (i_link_suspend || !i_configured |=> o_power_enable_n)
    else $error("power enable low while idle");
  pwr_on_a: assert property ((i_configured && !i_link_suspend && i_host_presence_n
    && o_cfg_mem_clock_oe)[*4] |=> !o_power_enable_n)
    else $error("power enable not low");
  sus_link_a: assert property (i_link_suspend |=> !o_suspend_n)
    else $error("suspend not shown");
  sus_wake_a: assert property ((!i_link_suspend && i_host_presence_n)[*4] |=> o_suspend_n)
    else $error("suspend shown while awake");
  save_ignored_a: assert property ((!o_cfg_valid && !i_link_suspend)[*2] |-> o_suspend_n)
    else $error("power save honoured before load");
endmodule
bind ups_top ups_top_chk chk (.*);
`default_nettype wire

/* tb/tb_ups_top.sv */
// bench for the usb power state pins
`timescale 1ns/10ps
`default_nettype none
module tb_ups_top;
  logic clk = 1'b0, rstn = 1'b0, susp = 1'b0, cfgd = 1'b0, hp_n = 1'b1;
  logic pen, sus, sel, sel_oe, mclk, mclk_oe, io_o, io_oe, valid, mem_q, io;
  logic [15:0] word = 16'h0000;
  logic [8:0] mem_cmd;
  int errors = 0, num_checks = 0, cyc = 0, rises = 0;
  always #5 clk = ~clk;
  always @(posedge mclk) rises++;
  // the data pin is shared: the memory answers only when the block lets go
  assign io = io_oe ? io_o : mem_q;
  ups_top dut (.i_ref_clk(clk), .i_resetn(rstn), .i_link_suspend(susp), .i_configured(cfgd),
    .i_host_presence_n(hp_n), .i_cfg_mem_io(io), .o_power_enable_n(pen), .o_suspend_n(sus),
    .o_cfg_mem_select(sel), .o_cfg_mem_select_oe(sel_oe), .o_cfg_mem_clock(mclk),
    .o_cfg_mem_clock_oe(mclk_oe), .o_cfg_mem_io(io_o), .o_cfg_mem_io_oe(io_oe),
    .o_cfg_valid(valid));
  ups_mem mem (.i_sel(sel), .i_clk(mclk), .i_din(io), .i_word(word), .o_dout(mem_q),
    .o_cmd(mem_cmd));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  // reset, word load, then the power-save pin before and after loading
  // the word's enable bit decides whether the held-low pin forces suspend
  task automatic t_boot(input logic [15:0] w);
    word <= w;
    rstn <= 1'b0;
    hp_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("reset pins", {sel_oe, mclk_oe, io_oe, pen}, 16'h0001);
    rises = 0;
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
    chk("early save", sus, 16'h0001);
    wait (valid === 1'b1);
    chk("mem clocks", rises[15:0], 16'h0019);
    chk("mem command", mem_cmd, 16'(ups_pkg::CMD_READ0));
    repeat (6) @(posedge clk);
    chk("forced", {sus, mclk_oe, sel_oe, sel}, {~w[ups_pkg::PSAVE_BIT], 3'h6});
    hp_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("released", sus, 16'h0001);
  endtask
  task automatic t_power;
    for (int i = 0; i < 4; i++)
    begin
      {susp, cfgd} <= 2'(i);
      repeat (3) @(posedge clk);
      chk("pen sus", {pen, sus}, {~(i[0] & ~i[1]), ~i[1]});
    end
    susp <= 1'b0;
  endtask
  initial
  begin
    // bit 1 set, bit 0 clear: a one-bit slip in sampling would enable power save
    t_boot(16'h0002);
    t_power();
    t_boot(16'h0001);
    t_power();
    end_sim();
  end
endmodule
`default_nettype wire
